// ===== dqr_regs.svh
// Constants for the device information query responder.
// Assumes plain 8-bit ASCII characters on the command link.
`ifndef DQR_REGS_SVH
`define DQR_REGS_SVH

// Command characters
`define DQR_CMD_KIND 8'h74
`define DQR_CMD_HWREV 8'h76
`define DQR_CMD_FWREV 8'h56
`define DQR_CMD_DATE 8'h44
`define DQR_CMD_PNUM 8'h4E
`define DQR_CMD_PID 8'h50
`define DQR_CMD_UPTM 8'h55
`define DQR_CMD_TOTL 8'h75
`define DQR_CMD_CPU 8'h43
`define DQR_CMD_RBT 8'h23

// Reply field lengths, in digits or characters
`define DQR_LEN_WORD 5'h04
`define DQR_LEN_PNUM 5'h08
`define DQR_LEN_UPTM 5'h12
`define DQR_LEN_TOTL 5'h10
`define DQR_LEN_CPU 5'h07
`define DQR_LEN_DATE 5'h0B
`define DQR_PID_MAX 16

// Time base: one fraction step is 1/256 s
`define DQR_CLK_PERIOD_NS 50
`define DQR_FRAC_PERIOD_NS 3906250
`define DQR_FRAC_CYCLES (`DQR_FRAC_PERIOD_NS / `DQR_CLK_PERIOD_NS)
`define DQR_FIFO_DEPTH 8

`endif

// ===== dqr_pkg.sv
// Types for the device information query responder.
// Assumes dqr_regs.svh is on the include path.
package dqr_pkg;
    typedef logic [7:0] dqr_char_t;
    typedef logic [15:0] dqr_word_t;
    typedef logic [31:0] dqr_dword_t;
    typedef enum logic [5:0] {
        DQR_IDLE = 6'b00_0001,
        DQR_WEOM = 6'b00_0010,
        DQR_SCMD = 6'b00_0100,
        DQR_BODY = 6'b00_1000,
        DQR_SEOM = 6'b01_0000,
        DQR_RBT = 6'b10_0000
    } dqr_state_t;
endpackage

// ===== dqr_fifo.sv
// Reply character FIFO, flip-flop storage indexed by pointers.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/10ps
module dqr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o,
    output logic empty_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ff;
    logic [AW-1:0] rd_ff;
    logic [AW:0] cnt_ff;
    logic push;
    logic pop;

    assign in_ready_o = (cnt_ff != DEPTH[AW:0]);
    assign out_valid_o = (cnt_ff != '0);
    assign empty_o = (cnt_ff == '0);
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem_ff[rd_ff];

    function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
        wrap_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_ff[wr_ff] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) wr_ff <= wrap_inc(wr_ff);
            if (pop) rd_ff <= wrap_inc(rd_ff);
            cnt_ff <= cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule // dqr_fifo

// ===== dqr_timekeep.sv
// Uptime, operating time and lifetime totals.
// Assumes reset comes from a device restart; totals are reloaded
// from nonvolatile storage after every reset release.
`timescale 1ns/10ps
`include "dqr_regs.svh"
module dqr_timekeep #(
    parameter int FRAC_CYCLES = `DQR_FRAC_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic active_i,
    input wire logic [31:0] nv_up_i,
    input wire logic [31:0] nv_op_i,
    output logic [31:0] sec_o,
    output logic [7:0] frac_o,
    output logic [31:0] op_o,
    output logic [31:0] tot_up_o,
    output logic [31:0] tot_op_o
);
    logic [16:0] pre_ff;
    logic [7:0] opfrac_ff;
    logic loaded_ff;
    logic tick;

    assign tick = (pre_ff == 17'(FRAC_CYCLES - 1));

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) pre_ff <= '0;
        else pre_ff <= tick ? '0 : pre_ff + 1'b1;
    end

    // Cleared only by reset, so uptime restarts with the device
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            frac_o <= '0;
            sec_o <= '0;
        end else if (tick) begin
            frac_o <= frac_o + 1'b1;
            if (frac_o == 8'hFF) sec_o <= sec_o + 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            opfrac_ff <= '0;
            op_o <= '0;
        end else if (tick && active_i) begin
            opfrac_ff <= opfrac_ff + 1'b1;
            if (opfrac_ff == 8'hFF) op_o <= op_o + 1'b1;
        end
    end

    // Totals are caught after release, never under reset itself
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            loaded_ff <= 1'b0;
            tot_up_o <= '0;
            tot_op_o <= '0;
        end else if (!loaded_ff) begin
            loaded_ff <= 1'b1;
            tot_up_o <= nv_up_i;
            tot_op_o <= nv_op_i;
        end else if (tick) begin
            if (frac_o == 8'hFF) tot_up_o <= tot_up_o + 1'b1;
            if (active_i && opfrac_ff == 8'hFF)
                tot_op_o <= tot_op_o + 1'b1;
        end
    end

    sec_wrap_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        tick && frac_o == 8'hFF |=> frac_o == 8'h00 &&
        sec_o == $past(sec_o) + 1)
        else $error("seconds did not advance on fraction wrap");
    op_hold_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        !active_i |=> op_o == $past(op_o))
        else $error("operating time moved while inactive");
endmodule // dqr_timekeep

// ===== dqr_top.sv
// Device information query responder: parses one-letter commands,
// answers through a reply FIFO, keeps time and requests restart.
// Assumes a UART outside handles bits and baud; characters arrive
// and leave as valid/ready bytes synchronous to CLK_I.
// Notes on behaviour
// - 't' replies 't', four hex digits of hardware kind, end mark.
// - 'v' replies 'v', four hex digits of hardware revision, end mark.
// - 'V' replies 'V', four hex digits of firmware revision, end mark.
// - Revision values are unsigned 16-bit with main and sub numbers.
// - Upper byte holds main revision, lower byte the sub-revision.
// - 'D' replies 'D' and eleven plain build date characters.
// - 'N' replies 'N' and eight hex digits of product number.
// - 'P' replies 'P' and identification text, no null sent.
// - 'U' replies seconds (8), fraction (2), operating time (8) hex.
// - Fraction counts 1/256 second steps.
// - Uptime counts since last start and clears on restart.
// - Operating time advances only while the device is activated.
// - Lifetime totals persist across restarts and power loss.
// - 'u' replies total uptime and total operating time, 8 hex each.
// - 'C' replies three hex digits load, four hex digits frequency.
// - Load in thousandths; frequency in 1024 Hz units.
// - Clock frequency is locked and serves as baud time base.
// - '#' echoes '#' then the device reboots.
// - Restart echo uses old baud; default rate applies afterwards.
`timescale 1ns/10ps
`include "dqr_regs.svh"
module dqr_top
    import dqr_pkg::*;
#(
    parameter int FRAC_CYCLES = `DQR_FRAC_CYCLES
) (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RST_B_I,
    // Received characters
    input wire logic RX_VALID_I,
    output logic RX_READY_O,
    input wire dqr_pkg::dqr_char_t RX_DATA_I,
    // Reply characters
    output logic TX_VALID_O,
    input wire logic TX_READY_I,
    output dqr_pkg::dqr_char_t TX_DATA_O,
    input wire logic TX_IDLE_I,
    // Identity and build values
    input wire dqr_pkg::dqr_word_t HW_KIND_I,
    input wire dqr_pkg::dqr_word_t HW_REV_I,
    input wire dqr_pkg::dqr_word_t FW_REV_I,
    input wire dqr_pkg::dqr_dword_t PROD_NUM_I,
    input wire logic [87:0] BUILD_DATE_I,
    input wire logic [127:0] PROD_ID_I,
    input wire logic [4:0] PROD_ID_LEN_I,
    // Processor status
    input wire logic [9:0] CPU_LOAD_I,
    input wire dqr_pkg::dqr_word_t CPU_FREQ_I,
    input wire logic ACTIVE_I,
    // Nonvolatile totals
    input wire dqr_pkg::dqr_dword_t NV_UP_I,
    input wire dqr_pkg::dqr_dword_t NV_OP_I,
    output dqr_pkg::dqr_dword_t TOT_UP_O,
    output dqr_pkg::dqr_dword_t TOT_OP_O,
    // Restart
    output logic REBOOT_O
);
    import dqr_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Reset release

    logic rst_meta_ff;
    logic rst_sync_ff;
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Declarations

    dqr_state_t st_ff;
    dqr_state_t nxt_st;
    dqr_char_t cmd_ff;
    dqr_char_t eom_ff;
    logic [127:0] shr_ff;
    logic [4:0] cnt_ff;
    logic hex_ff;
    logic reboot_ff;
    logic rx_fire;
    logic push;
    logic f_ready;
    logic f_empty;
    dqr_char_t push_data;
    logic [31:0] sec;
    logic [7:0] frac;
    logic [31:0] optm;

    function automatic dqr_char_t hex_ascii(input logic [3:0] n);
        hex_ascii = (n < 4'hA) ? 8'h30 + {4'h0, n}
                               : 8'h37 + {4'h0, n};
    endfunction

    function automatic logic known_cmd(input dqr_char_t c);
        known_cmd = c inside {`DQR_CMD_KIND, `DQR_CMD_HWREV,
            `DQR_CMD_FWREV, `DQR_CMD_DATE, `DQR_CMD_PNUM,
            `DQR_CMD_PID, `DQR_CMD_UPTM, `DQR_CMD_TOTL,
            `DQR_CMD_CPU, `DQR_CMD_RBT};
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Command intake and reply sequencing

    assign RX_READY_O = (st_ff == DQR_IDLE) || (st_ff == DQR_WEOM);
    assign rx_fire = RX_VALID_I && RX_READY_O;

    always_comb begin
        nxt_st = st_ff;
        unique case (st_ff)
            DQR_IDLE: begin
                if (rx_fire && known_cmd(RX_DATA_I)) nxt_st = DQR_WEOM;
            end
            DQR_WEOM: begin
                if (rx_fire) nxt_st = DQR_SCMD;
            end
            DQR_SCMD: begin
                if (f_ready) nxt_st = (cnt_ff == '0) ? DQR_SEOM : DQR_BODY;
            end
            DQR_BODY: begin
                if (f_ready && cnt_ff == 5'h01) nxt_st = DQR_SEOM;
            end
            DQR_SEOM: begin
                if (f_ready)
                    nxt_st = (cmd_ff == `DQR_CMD_RBT) ? DQR_RBT : DQR_IDLE;
            end
            DQR_RBT: begin
                if (reboot_ff) nxt_st = DQR_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_I or negedge rst_sync_ff) begin
        if (!rst_sync_ff) st_ff <= DQR_IDLE;
        else st_ff <= nxt_st;
    end

    always_ff @(posedge CLK_I or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            cmd_ff <= 8'h00;
            eom_ff <= 8'h00;
        end else if (rx_fire && st_ff == DQR_IDLE) begin
            cmd_ff <= RX_DATA_I;
        end else if (rx_fire) begin
            eom_ff <= RX_DATA_I;
        end
    end

    // Fields are snapshot with the end mark so multi-field replies
    // are coherent; the cost is a 128-bit shift register.
    always_ff @(posedge CLK_I or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            shr_ff <= '0;
            cnt_ff <= '0;
            hex_ff <= 1'b1;
        end else if (rx_fire && st_ff == DQR_WEOM) begin
            hex_ff <= 1'b1;
            shr_ff <= '0;
            cnt_ff <= '0;
            unique case (cmd_ff)
                `DQR_CMD_KIND: begin
                    shr_ff[127:112] <= HW_KIND_I;
                    cnt_ff <= `DQR_LEN_WORD;
                end
                `DQR_CMD_HWREV: begin
                    shr_ff[127:112] <= HW_REV_I;
                    cnt_ff <= `DQR_LEN_WORD;
                end
                `DQR_CMD_FWREV: begin
                    shr_ff[127:112] <= FW_REV_I;
                    cnt_ff <= `DQR_LEN_WORD;
                end
                `DQR_CMD_DATE: begin
                    shr_ff[127:40] <= BUILD_DATE_I;
                    cnt_ff <= `DQR_LEN_DATE;
                    hex_ff <= 1'b0;
                end
                `DQR_CMD_PNUM: begin
                    shr_ff[127:96] <= PROD_NUM_I;
                    cnt_ff <= `DQR_LEN_PNUM;
                end
                `DQR_CMD_PID: begin
                    // Length excludes any terminator; capped at 16
                    shr_ff <= PROD_ID_I;
                    cnt_ff <= (PROD_ID_LEN_I > 5'(`DQR_PID_MAX))
                        ? 5'(`DQR_PID_MAX) : PROD_ID_LEN_I;
                    hex_ff <= 1'b0;
                end
                `DQR_CMD_UPTM: begin
                    shr_ff[127:56] <= {sec, frac, optm};
                    cnt_ff <= `DQR_LEN_UPTM;
                end
                `DQR_CMD_TOTL: begin
                    shr_ff[127:64] <= {TOT_UP_O, TOT_OP_O};
                    cnt_ff <= `DQR_LEN_TOTL;
                end
                `DQR_CMD_CPU: begin
                    // Frequency word comes from the locking loop that
                    // also clocks the UART baud divider
                    shr_ff[127:100] <= {2'b00, CPU_LOAD_I,
                        CPU_FREQ_I};
                    cnt_ff <= `DQR_LEN_CPU;
                end
                default: begin
                    cnt_ff <= '0;
                end
            endcase
        end else if (st_ff == DQR_BODY && f_ready) begin
            // Most significant digit or character leaves first
            shr_ff <= hex_ff ? {shr_ff[123:0], 4'h0}
                             : {shr_ff[119:0], 8'h00};
            cnt_ff <= cnt_ff - 1'b1;
        end
    end

    always_comb begin
        push = 1'b0;
        push_data = 8'h00;
        unique case (st_ff)
            DQR_SCMD: begin
                push = 1'b1;
                push_data = cmd_ff;
            end
            DQR_BODY: begin
                push = 1'b1;
                push_data = hex_ff ? hex_ascii(shr_ff[127:124])
                                   : shr_ff[127:120];
            end
            DQR_SEOM: begin
                push = 1'b1;
                push_data = eom_ff;
            end
            default: begin
                push = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Restart request

    // Reboot waits until the echo has fully left at the current rate;
    // the UART returns to its default rate with the restart reset.
    always_ff @(posedge CLK_I or negedge rst_sync_ff) begin
        if (!rst_sync_ff) reboot_ff <= 1'b0;
        else reboot_ff <= (st_ff == DQR_RBT) && f_empty && TX_IDLE_I &&
            !reboot_ff;
    end
    assign REBOOT_O = reboot_ff;

    ////////////////////////////////////////////////////////////////////
    // Submodules

    dqr_fifo #(
        .WIDTH(8),
        .DEPTH(`DQR_FIFO_DEPTH)
    ) u_fifo (
        .clk_i(CLK_I),
        .rst_n_i(rst_sync_ff),
        .in_valid_i(push),
        .in_ready_o(f_ready),
        .in_data_i(push_data),
        .out_valid_o(TX_VALID_O),
        .out_ready_i(TX_READY_I),
        .out_data_o(TX_DATA_O),
        .empty_o(f_empty)
    );

    dqr_timekeep #(
        .FRAC_CYCLES(FRAC_CYCLES)
    ) u_time (
        .clk_i(CLK_I),
        .rst_n_i(rst_sync_ff),
        .active_i(ACTIVE_I),
        .nv_up_i(NV_UP_I),
        .nv_op_i(NV_OP_I),
        .sec_o(sec),
        .frac_o(frac),
        .op_o(optm),
        .tot_up_o(TOT_UP_O),
        .tot_op_o(TOT_OP_O)
    );

    ////////////////////////////////////////////////////////////////////
    // Checks

    logic snap;
    assign snap = rx_fire && st_ff == DQR_WEOM;

    kind_len_a: assert property (
        @(posedge CLK_I) disable iff (!rst_sync_ff)
        snap && cmd_ff == `DQR_CMD_KIND |=> cnt_ff == 5'h04 && hex_ff
        && shr_ff[127:112] == $past(HW_KIND_I))
        else $error("kind reply not four hex digits");
    hwrev_len_a: assert property (
        @(posedge CLK_I) disable iff (!rst_sync_ff)
        snap && cmd_ff == `DQR_CMD_HWREV |=> cnt_ff == 5'h04 && hex_ff)
        else $error("hardware revision length wrong");
    fwrev_len_a: assert property (
        @(posedge CLK_I) disable iff (!rst_sync_ff)
        snap && cmd_ff == `DQR_CMD_FWREV |=> cnt_ff == 5'h04 && hex_ff)
        else $error("firmware revision length wrong");
    date_text_a: assert property (
        @(posedge CLK_I) disable iff (!rst_sync_ff)
        snap && cmd_ff == `DQR_CMD_DATE |=> cnt_ff == 5'h0B && !hex_ff)
        else $error("date reply not eleven characters");
    pnum_len_a: assert property (
        @(posedge CLK_I) disable iff (!rst_sync_ff)
        snap && cmd_ff == `DQR_CMD_PNUM |=> cnt_ff == 5'h08)
        else $error("product number length wrong");
    uptm_len_a: assert property (
        @(posedge CLK_I) disable iff (!rst_sync_ff)
        snap && cmd_ff == `DQR_CMD_UPTM |=> cnt_ff == 5'h12)
        else $error("uptime reply length wrong");
    cpu_len_a: assert property (
        @(posedge CLK_I) disable iff (!rst_sync_ff)
        snap && cmd_ff == `DQR_CMD_CPU |=> cnt_ff == 5'h07)
        else $error("cpu reply length wrong");
    cmd_echo_a: assert property (
        @(posedge CLK_I) disable iff (!rst_sync_ff)
        st_ff == DQR_SCMD |-> push && known_cmd(cmd_ff))
        else $error("reply does not start with a known command");
    rbt_seq_a: assert property (
        @(posedge CLK_I) disable iff (!rst_sync_ff)
        st_ff == DQR_SEOM && f_ready && cmd_ff == `DQR_CMD_RBT
        |=> st_ff == DQR_RBT)
        else $error("restart not entered after echo");
    rbt_drain_a: assert property (
        @(posedge CLK_I) disable iff (!rst_sync_ff)
        REBOOT_O |-> $past(f_empty) && $past(TX_IDLE_I))
        else $error("reboot before echo left");
endmodule // dqr_top

// ===== dqr_host_model.sv
// Host side model: sends command characters and collects the replies.
// Assumes the responder's valid/ready byte ports on one clock.
`timescale 1ns/10ps
module dqr_host_model
    import dqr_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Command characters to the device
    output logic rx_valid_o,
    input wire logic rx_ready_i,
    output dqr_pkg::dqr_char_t rx_data_o,
    // Reply characters from the device
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    input wire dqr_pkg::dqr_char_t tx_data_i,
    output logic tx_idle_o,
    // Test controls
    input wire logic slow_i,
    input wire logic busy_i
);
    dqr_char_t got[$];
    logic [1:0] div_ff = 2'h0;
    logic [2:0] quiet_ff = 3'h0;

    initial begin
        rx_valid_o = 1'b0;
        rx_data_o = 8'h00;
    end

    // Slow mode takes one character in four, like a real shifter
    assign tx_ready_o = !slow_i || (div_ff == 2'h3);
    // Shifter reads empty only a while after the last character
    assign tx_idle_o = !busy_i && (quiet_ff == 3'h7);

    always @(posedge clk_i) begin
        div_ff <= div_ff + 2'h1;
        if (tx_valid_i && tx_ready_o) begin
            got.push_back(tx_data_i);
            quiet_ff <= 3'h0;
        end else if (quiet_ff != 3'h7) begin
            quiet_ff <= quiet_ff + 3'h1;
        end
    end

    // Held until an edge sees ready; released data is inverted so
    // a stale value cannot pass for a fresh one
    task automatic send(input dqr_char_t c);
        rx_valid_o <= 1'b1;
        rx_data_o <= c;
        do @(posedge clk_i); while (rx_ready_i !== 1'b1);
        rx_valid_o <= 1'b0;
        rx_data_o <= ~c;
        @(posedge clk_i);
    endtask
endmodule // dqr_host_model

// ===== dqr_top_test.sv
// Self-checking bench for the query responder.
// Assumes the host model stands in for the UART and the host.
`timescale 1ns/10ps
`include "dqr_regs.svh"
module dqr_top_test;
    import dqr_pkg::*;
    // Short fraction step keeps a second at 1024 clocks
    localparam int FRAC = 4;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic rx_valid, rx_ready, tx_valid, tx_ready, tx_idle, reboot;
    dqr_char_t rx_data, tx_data;
    dqr_word_t hw_kind = 16'hA5C3;
    dqr_word_t hw_rev = 16'h0312;
    dqr_word_t fw_rev = 16'h1F0E;
    dqr_dword_t prod_num = 32'h8D0B_47E1;
    logic [87:0] build_date = "Build-0042x";
    logic [127:0] prod_id = {"Probe unit 7", 32'h5A5A_5A5A};
    logic [4:0] prod_id_len = 5'h0C;
    logic [9:0] cpu_load = 10'h3E7;
    dqr_word_t cpu_freq = 16'h3BD4;
    logic active = 1'b0;
    logic slow = 1'b0;
    logic busy = 1'b0;
    dqr_dword_t nv_up = 32'h0000_1000;
    dqr_dword_t nv_op = 32'h0000_0200;
    dqr_dword_t tot_up, tot_op;
    dqr_char_t exp[$];
    int num_errors = 0;
    int tests_run = 0;

    initial begin
        forever #25 clk = ~clk;
    end

    dqr_top #(.FRAC_CYCLES(FRAC)) i_dqr_top (.CLK_I(clk), .RST_B_I(rst_b),
        .RX_VALID_I(rx_valid), .RX_READY_O(rx_ready), .RX_DATA_I(rx_data),
        .TX_VALID_O(tx_valid), .TX_READY_I(tx_ready), .TX_DATA_O(tx_data),
        .TX_IDLE_I(tx_idle), .HW_KIND_I(hw_kind), .HW_REV_I(hw_rev),
        .FW_REV_I(fw_rev), .PROD_NUM_I(prod_num),
        .BUILD_DATE_I(build_date), .PROD_ID_I(prod_id),
        .PROD_ID_LEN_I(prod_id_len), .CPU_LOAD_I(cpu_load),
        .CPU_FREQ_I(cpu_freq), .ACTIVE_I(active), .NV_UP_I(nv_up),
        .NV_OP_I(nv_op), .TOT_UP_O(tot_up), .TOT_OP_O(tot_op),
        .REBOOT_O(reboot));

    dqr_host_model i_dqr_host_model (.clk_i(clk), .rx_valid_o(rx_valid),
        .rx_ready_i(rx_ready), .rx_data_o(rx_data), .tx_valid_i(tx_valid),
        .tx_ready_o(tx_ready), .tx_data_i(tx_data), .tx_idle_o(tx_idle),
        .slow_i(slow), .busy_i(busy));

    ////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        tests_run++;
        if (seen !== want) begin
            num_errors++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask

    // Uppercase ASCII digits, most significant first
    task automatic hex(input logic [31:0] v, input int n);
        logic [3:0] d;
        for (int i = n - 1; i >= 0; i--) begin
            d = v[i*4 +: 4];
            exp.push_back(d < 4'hA ? 8'h30 + {4'h0, d} : 8'h37 + {4'h0, d});
        end
    endtask

    // A '?' in the expected reply marks a digit that is not compared
    task automatic query(input dqr_char_t cmd, input dqr_char_t eom);
        int n;
        exp.push_front(cmd);
        exp.push_back(eom);
        i_dqr_host_model.got.delete();
        i_dqr_host_model.send(cmd);
        i_dqr_host_model.send(eom);
        n = 0;
        while (i_dqr_host_model.got.size() < exp.size() && n < 400) begin
            @(posedge clk);
            n++;
        end
        repeat (8) @(posedge clk);
        check(i_dqr_host_model.got.size(), exp.size());
        foreach (exp[i]) begin
            if (exp[i] != 8'h3F) begin
                check(i_dqr_host_model.got[i], exp[i]);
            end
        end
        exp.delete();
    endtask

    task automatic test_done();
        if (num_errors == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    task automatic test_time_early();
        check(tot_up, nv_up);
        hex(32'h0, 8);
        exp.push_back(8'h3F);
        exp.push_back(8'h3F);
        hex(32'h0, 8);
        query(`DQR_CMD_UPTM, 8'h0D);
        hex(nv_up, 8);
        hex(nv_op, 8);
        query(`DQR_CMD_TOTL, 8'h0D);
    endtask

    task automatic test_ids();
        for (int k = 0; k < 2; k++) begin
            slow <= k[0];
            if (k == 1) begin
                hw_kind <= 16'h5A3C;
                hw_rev <= 16'h0C07;
                fw_rev <= 16'hE0F1;
                prod_num <= 32'h72F4_B81E;
            end
            @(posedge clk);
            hex(hw_kind, 4);
            query(`DQR_CMD_KIND, k ? 8'h21 : 8'h0D);
            hex({16'h0, k ? 8'h0C : 8'h03, k ? 8'h07 : 8'h12}, 4);
            query(`DQR_CMD_HWREV, k ? 8'h21 : 8'h0D);
            hex(fw_rev, 4);
            query(`DQR_CMD_FWREV, k ? 8'h21 : 8'h0D);
            hex(prod_num, 8);
            query(`DQR_CMD_PNUM, k ? 8'h21 : 8'h0D);
        end
        slow <= 1'b0;
    endtask

    task automatic test_text();
        // An unknown command is dropped and leaves no reply behind
        i_dqr_host_model.send(8'h78);
        for (int i = 10; i >= 0; i--) exp.push_back(build_date[i*8 +: 8]);
        query(`DQR_CMD_DATE, 8'h0D);
        for (int i = 15; i >= 4; i--) exp.push_back(prod_id[i*8 +: 8]);
        query(`DQR_CMD_PID, 8'h0D);
        // Lengths above sixteen are capped at the whole buffer
        prod_id_len <= 5'h14;
        @(posedge clk);
        for (int i = 15; i >= 0; i--) exp.push_back(prod_id[i*8 +: 8]);
        query(`DQR_CMD_PID, 8'h0D);
    endtask

    task automatic test_cpu();
        for (int k = 0; k < 2; k++) begin
            cpu_load <= k ? 10'h3E8 : 10'h001;
            cpu_freq <= k ? 16'hF001 : 16'h3BD4;
            @(posedge clk);
            hex(k ? 32'h3E8 : 32'h001, 3);
            hex({16'h0, cpu_freq}, 4);
            query(`DQR_CMD_CPU, 8'h0D);
        end
    endtask

    task automatic test_optime();
        repeat (2100) @(posedge clk);
        hex(32'h0, 7);
        repeat (3) exp.push_back(8'h3F);
        hex(32'h0, 8);
        query(`DQR_CMD_UPTM, 8'h0D);
        check(i_dqr_host_model.got[8] != 8'h30, 1'b1);
        active <= 1'b1;
        repeat (2100) @(posedge clk);
        hex(32'h0, 7);
        repeat (3) exp.push_back(8'h3F);
        hex(32'h0, 7);
        exp.push_back(8'h3F);
        query(`DQR_CMD_UPTM, 8'h0D);
        check(i_dqr_host_model.got[18] != 8'h30, 1'b1);
        active <= 1'b0;
    endtask

    task automatic test_restart();
        int n;
        busy <= 1'b1;
        query(`DQR_CMD_RBT, 8'h0D);
        n = 0;
        repeat (20) begin
            @(posedge clk);
            n += (reboot !== 1'b0);
        end
        check(n, 0);
        busy <= 1'b0;
        n = 0;
        while (reboot !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        check(reboot, 1'b1);
        // Outside logic saves the totals and restarts the device; the
        // host stays silent until the restart is over
        nv_up <= tot_up;
        nv_op <= tot_op;
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        repeat (5) @(posedge clk);
        check(tot_up, nv_up);
        hex(32'h0, 8);
        exp.push_back(8'h3F);
        exp.push_back(8'h3F);
        hex(32'h0, 8);
        query(`DQR_CMD_UPTM, 8'h0D);
        hex(nv_up, 8);
        hex(nv_op, 8);
        query(`DQR_CMD_TOTL, 8'h0D);
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        repeat (5) @(posedge clk);
        test_time_early();
        test_ids();
        test_text();
        test_cpu();
        test_optime();
        test_restart();
        test_done();
    end

    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        test_done();
    end
endmodule // dqr_top_test
